// ---- rtl/dramc_pkg.sv ----
/*
  dramc_pkg: constants for the controller of a 64k x 1 asynchronous dram.
  assumes a 25 MHz mclk; all strobe timing is counted in mclk cycles.
*/
package dramc_pkg;
  // clock
  localparam int unsigned CLK_NS           = 40;
  // array geometry
  localparam int unsigned ADDR_W           = 16;
  localparam int unsigned HALF_W           = 8;
  localparam int unsigned ROW_COUNT        = 256;
  // strobe phase lengths in ns, turned into cycles (rounded up)
  localparam int unsigned T_RCD_NS         = 40;
  localparam int unsigned T_CAS_NS         = 80;
  localparam int unsigned T_RP_NS          = 120;
  localparam int unsigned T_CP_NS          = 40;
  localparam int unsigned T_WP_NS          = 40;
  localparam logic [3:0]  RCD_CYC          = 4'((T_RCD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0]  CAS_CYC          = 4'((T_CAS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0]  RP_CYC           = 4'((T_RP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0]  CP_CYC           = 4'((T_CP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0]  WP_CYC           = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  // power-up pause and warm-up cycles
  localparam int unsigned T_PWRUP_US       = 100;
  localparam int unsigned PWRUP_CYC        = T_PWRUP_US * 1000 / CLK_NS;
  localparam logic [3:0]  WARMUP_CNT       = 4'h8;
  // distributed refresh interval 15.625 us, rounded down
  localparam int unsigned T_REF_PS         = 15625000;
  localparam int unsigned REF_CYC          = T_REF_PS / (CLK_NS * 1000);
  // access kinds on the user port
  localparam logic [1:0]  OP_READ          = 2'h0;
  localparam logic [1:0]  OP_WRITE         = 2'h1;
  localparam logic [1:0]  OP_RMW           = 2'h2;
endpackage : dramc_pkg

// ---- rtl/dramc_tick.sv ----
/*
  dramc_tick: down counter giving a one-cycle pulse every PERIOD cycles.
  assumes PERIOD fits in 16 bits; synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module dramc_tick #(
  parameter int unsigned PERIOD = 390
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // pulse out
  output logic      tick
);
  logic [15:0] cnt_reg;  // cycles left

  assign tick = (cnt_reg == 16'h0000);

  // reload on expiry, so tick is exactly one cycle wide
  always_ff @(posedge mclk) begin
    if (rst || tick) begin
      cnt_reg <= 16'(PERIOD - 1);
    end else begin
      cnt_reg <= cnt_reg - 16'h0001;
    end
  end
endmodule : dramc_tick
`default_nettype wire

// ---- rtl/dramc_ctrl.sv ----
/*
  dramc_ctrl: controller that drives a 64k x 1 asynchronous dram through
  its strobes, multiplexed address and split data pins.
  assumes the dram pins are sampled/driven on mclk; one access at a time.
*/
// Function
// RQ1 - 64k one-bit cells, 16-bit address, split data
// RQ2 - row half then column half on strobes
// RQ3 - early write keeps dram output undriven
// RQ4 - late write output held while column low
// RQ5 - late write pulse gives read-modify-write
// RQ6 - write data captured at write strobe fall
// RQ7 - page mode: row low, column toggles
// RQ8 - row strobe high ends the cycle
// RQ9 - row high precharge between row cycles
// RQ10 - all 256 rows refreshed every 4 ms
// RQ11 - row-only, column-before-row and hidden refresh; the controller issues only column-before-row refresh
// RQ12 - shared data wire: use early write
// RQ13 - 100 us pause then eight row cycles
// RQ14 - dram output idle while column high
// RQ15 - one refresh every 15.625 us
// RQ16 - column-before-row refresh uses internal counter
`timescale 1ns/1ps
`default_nettype none
module dramc_ctrl
  import dramc_pkg::*;
#(
  parameter int unsigned PWRUP_CYCLES = PWRUP_CYC  // shorten in simulation
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // user request
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic [1:0]        req_op,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic              req_wdata,
  input  wire logic              req_page,
  // user answer
  output logic                   rsp_valid,
  output logic                   rsp_rdata,
  output logic                   init_done,
  // dram pins
  output logic                   ras_n,
  output logic                   cas_n,
  output logic                   we_n,
  output logic [HALF_W-1:0]      dram_addr,
  output logic                   dram_din,
  input  wire logic              dram_dout
);
  // controller states, one-hot
  typedef enum logic [8:0] {
    ST_PWRUP = 9'h001, ST_IDLE = 9'h002, ST_RAS = 9'h004,
    ST_CAS   = 9'h008, ST_WE   = 9'h010, ST_CPRE = 9'h020,
    ST_PRE   = 9'h040, ST_CBR  = 9'h080, ST_CBRR = 9'h100
  } dramc_state_t;

  dramc_state_t      state_reg, state_next;
  logic [16:0]       wait_reg;        // phase / power-up counter
  logic [3:0]        warm_reg;        // warm-up row cycles left
  logic [HALF_W-1:0] row_reg;         // open row
  logic [HALF_W-1:0] col_reg;         // column of current access
  logic [1:0]        op_reg;          // kind of current access
  logic              wd_reg;          // data to write
  logic              ref_pend_reg;    // refresh owed
  logic              ras_reg, cas_reg, we_reg;
  logic [HALF_W-1:0] addr_reg;
  logic              rdata_reg, rsp_reg, done_reg;
  logic              ref_tick;

  // refresh pacing
  dramc_tick #(.PERIOD(REF_CYC)) u_ref (
    .mclk (mclk),
    .rst  (rst),
    .tick (ref_tick)   // RQ15
  );

  // decode
  wire wait_done = (wait_reg == 17'h00000);
  wire is_write  = (op_reg == OP_WRITE);
  wire is_rmw    = (op_reg == OP_RMW);
  wire take      = req_valid && req_ready;
  // a page hit may reuse the open row while ras stays low
  wire page_hit  = req_valid && req_page && (req_addr[15:8] == row_reg) && !ref_pend_reg;
  // new request latched this edge; pins must already see its halves and kind,
  // else the row strobe falls on the previous row and we trails the column strobe
  wire                reload  = take || (state_reg == ST_CPRE && wait_done && page_hit);
  wire [HALF_W-1:0]   row_src = reload ? req_addr[15:8] : row_reg;  // row on the pins
  wire [HALF_W-1:0]   col_src = reload ? req_addr[7:0] : col_reg;   // column on the pins
  wire [1:0]          op_src  = reload ? req_op : op_reg;           // kind driving we

  assign req_ready = (state_reg == ST_IDLE) && done_reg && !ref_pend_reg;
  assign ras_n     = ras_reg;
  assign cas_n     = cas_reg;
  assign we_n      = we_reg;
  assign dram_addr = addr_reg;
  assign dram_din  = wd_reg;
  assign rsp_valid = rsp_reg;
  assign rsp_rdata = rdata_reg;
  assign init_done = done_reg;

  // next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_PWRUP: if (wait_done) state_next = ST_CBR;                    // RQ13
      ST_IDLE:  if (ref_pend_reg || !done_reg) state_next = ST_CBR;    // RQ10
                else if (take) state_next = ST_RAS;
      ST_RAS:   if (wait_done) state_next = ST_CAS;                    // RQ2
      ST_CAS:   if (wait_done) state_next = is_rmw ? ST_WE : ST_CPRE;
      ST_WE:    if (wait_done) state_next = ST_CPRE;                   // RQ5
      ST_CPRE:  if (wait_done) state_next = page_hit ? ST_CAS : ST_PRE;  // RQ7
      ST_PRE:   if (wait_done) state_next = ST_IDLE;                   // RQ9
      ST_CBR:   if (wait_done) state_next = ST_CBRR;                   // RQ16
      ST_CBRR:  if (wait_done) state_next = ST_PRE;
      default:  state_next = ST_PWRUP;
    endcase
  end

  // state and phase counter
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= ST_PWRUP;
      wait_reg  <= 17'(PWRUP_CYCLES);
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg || (state_reg == ST_CPRE && wait_done)) begin
        case (state_next)
          ST_RAS:  wait_reg <= 17'(RCD_CYC - 1);
          ST_CAS:  wait_reg <= 17'(CAS_CYC - 1);
          ST_WE:   wait_reg <= 17'(WP_CYC - 1);
          ST_CPRE: wait_reg <= 17'(CP_CYC - 1);
          ST_PRE:  wait_reg <= 17'(RP_CYC - 1);
          ST_CBR:  wait_reg <= 17'(CP_CYC - 1);
          ST_CBRR: wait_reg <= 17'(CAS_CYC - 1);
          default: wait_reg <= 17'h00000;
        endcase
      end else if (!wait_done) begin
        wait_reg <= wait_reg - 17'h00001;
      end
    end
  end

  // latch request; page hits keep the row and reload column, kind and data
  always_ff @(posedge mclk) begin
    if (rst) begin
      row_reg <= 8'h00;
      col_reg <= 8'h00;
      op_reg  <= OP_READ;
      wd_reg  <= 1'b0;
    end else if (reload) begin
      row_reg <= req_addr[15:8];   // RQ1
      col_reg <= req_addr[7:0];
      op_reg  <= req_op;
      wd_reg  <= req_wdata;        // RQ6
    end
  end

  // refresh owed; a new tick wins over the clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      ref_pend_reg <= 1'b0;
    end else if (ref_tick) begin
      ref_pend_reg <= 1'b1;                                  // RQ15
    end else if (state_reg == ST_CBR) begin
      ref_pend_reg <= 1'b0;
    end
  end

  // warm-up row cycles after the pause, all cas-before-ras
  always_ff @(posedge mclk) begin
    if (rst) begin
      warm_reg <= WARMUP_CNT;
      done_reg <= 1'b0;
    end else if (state_reg == ST_CBRR && wait_done && !done_reg) begin
      warm_reg <= warm_reg - 4'h1;                           // RQ13
      done_reg <= (warm_reg == 4'h1);
    end
  end

  // pin drive, registered from the next state
  always_ff @(posedge mclk) begin
    if (rst) begin
      ras_reg  <= 1'b1;
      cas_reg  <= 1'b1;
      we_reg   <= 1'b1;
      addr_reg <= 8'h00;
    end else begin
      // ras low through the whole row cycle, high in precharge
      ras_reg  <= !(state_next inside {ST_RAS, ST_CAS, ST_WE, ST_CPRE, ST_CBRR});  // RQ8
      // cbr drops cas before ras; nothing else of ours has cas low with ras high
      cas_reg  <= !(state_next inside {ST_CAS, ST_WE, ST_CBR, ST_CBRR});     // RQ16
      // early write: we low before cas falls, or with it on a page-hit write; output stays open
      we_reg   <= !((state_next inside {ST_RAS, ST_CAS} && op_src == OP_WRITE)
                    || state_next == ST_WE);                                 // RQ12
      addr_reg <= (state_next == ST_CAS) ? col_src : row_src;                // RQ2
    end
  end

  // read data sampled in the last cycle of the column phase for reads and rmw
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_reg <= 1'b0;
      rsp_reg   <= 1'b0;
    end else begin
      rsp_reg <= (state_reg == ST_CAS) && wait_done && !is_write;  // RQ4
      if ((state_reg == ST_CAS) && wait_done && !is_write) begin
        rdata_reg <= dram_dout;                                    // RQ14
      end
    end
  end

  // checks
  AST_RAS_HIGH_IN_PRE: assert property (@(posedge mclk) disable iff (rst)
    (state_reg == ST_PRE) |=> ras_n) else $error("ras low in precharge");  // RQ9
  // we must already be low in the cycle before the column strobe falls
  AST_EARLY_WRITE: assert property (@(posedge mclk) disable iff (rst)
    ($fell(cas_n) && !ras_n && is_write && $past(state_reg) == ST_RAS)
    |-> (!we_n && !$past(we_n))) else $error("we late in write");  // RQ12
  AST_CBR_ORDER: assert property (@(posedge mclk) disable iff (rst)
    ($fell(ras_n) && $past(state_reg) == ST_CBR) |-> !cas_n) else $error("cbr order");  // RQ16
  AST_RMW_WE: assert property (@(posedge mclk) disable iff (rst)
    (state_reg == ST_WE) |-> (!we_n && !cas_n)) else $error("rmw we not low");  // RQ5
  AST_REF_SERVED: assert property (@(posedge mclk) disable iff (rst)
    (ref_tick && done_reg) |-> ##[1:40] (state_reg == ST_CBR)) else $error("refresh late");  // RQ10
  AST_ADDR_COL: assert property (@(posedge mclk) disable iff (rst)
    (state_reg == ST_CAS) |-> (dram_addr == col_reg)) else $error("column missing");  // RQ2
  AST_RSP_PULSE: assert property (@(posedge mclk) disable iff (rst)
    rsp_valid |=> !rsp_valid) else $error("rsp not a pulse");  // RQ4
  AST_WARM_EIGHT: assert property (@(posedge mclk) disable iff (rst)
    $rose(done_reg) |-> (warm_reg == 4'h0)) else $error("warm-up count");  // RQ13
  COV_READ:  cover property (@(posedge mclk) rsp_valid && op_reg == OP_READ);
  COV_RMW:   cover property (@(posedge mclk) state_reg == ST_WE);
  COV_PAGE:  cover property (@(posedge mclk) state_reg == ST_CPRE && state_next == ST_CAS);
  COV_REF:   cover property (@(posedge mclk) done_reg && state_reg == ST_CBRR);
endmodule : dramc_ctrl
`default_nettype wire

// ---- testbench/dramc_dram_model.sv ----
/*
  dramc_dram_model: behavioural 64k x 1 dram on the far side of dramc_ctrl.
  assumes strobes come from the controller; no clock, it reacts to strobe edges.
*/
`timescale 1ns/1ps
`default_nettype none
module dramc_dram_model
  import dramc_pkg::*;
(
  // strobes and address
  input  wire logic              ras_n,
  input  wire logic              cas_n,
  input  wire logic              we_n,
  input  wire logic [HALF_W-1:0] dram_addr,
  // data
  input  wire logic              dram_din,
  output logic                   dram_dout,
  // counters for the bench
  output var logic [15:0]        ref_cnt,
  output var logic [15:0]        late_cnt
);
  logic              mem [0:(1<<ADDR_W)-1]; // one bit per cell
  logic [HALF_W-1:0] row_q, col_q, ref_row; // latched halves, refresh row
  logic              drive, last;           // output enable, last read bit
  // preload a pattern so a missed write is visible
  initial begin
    for (int i = 0; i < (1<<ADDR_W); i++) mem[i] = i[0];
    {row_q, col_q, ref_row, drive, last, ref_cnt, late_cnt} = '0;
  end
  // row fall: refresh from own counter if column already low, else latch row
  // strobes and address move on one clock edge; look once they have settled
  always @(negedge ras_n) begin
    #1;
    if (!cas_n) begin
      ref_row = ref_row + 8'h01;
      ref_cnt = ref_cnt + 16'h0001;
    end else row_q = dram_addr;
  end
  // column fall inside an open row: early write or read
  always @(negedge cas_n) begin
    #1;
    if (!ras_n) begin
      col_q = dram_addr;
      if (!we_n) mem[{row_q, col_q}] = dram_din;
      else begin
        last  = mem[{row_q, col_q}];
        drive = 1'b1;
      end
    end
  end
  // late write strobe turns the access into read-modify-write
  always @(negedge we_n) begin
    #1;
    if (!ras_n && !cas_n) begin
      mem[{row_q, col_q}] = dram_din;
      late_cnt = late_cnt + 16'h0001;
    end
  end
  // column high releases the output; latched halves survive a row close
  always @(posedge cas_n) drive = 1'b0;
  // released line shows the inverse so a stale sample cannot match
  assign dram_dout = drive ? last : ~last;
endmodule : dramc_dram_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
/*
  tb_top: self-checking bench for dramc_ctrl against a behavioural dram.
  assumes dramc_pkg; inputs change on the falling mclk edge.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dramc_pkg::*;
  // user side
  logic              mclk, rst, req_valid, req_ready, req_wdata, req_page;
  logic              rsp_valid, rsp_rdata, init_done;
  logic [1:0]        req_op;
  logic [ADDR_W-1:0] req_addr;
  // dram pins and model counters
  logic              ras_n, cas_n, we_n, dram_din, dram_dout;
  logic [HALF_W-1:0] dram_addr;
  logic [15:0]       ref_cnt, late_cnt, r;
  // bookkeeping
  int                errors, tests_run, cycles, ras_rise, hi_run, min_hi, n;
  logic              rd, rd2;
  logic [15:0]       tbl [4] = '{16'h0000, 16'hffff, 16'h12a5, 16'ha512};

  dramc_ctrl #(.PWRUP_CYCLES(20)) dramc_ctrl_inst (.mclk(mclk), .rst(rst),
    .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_page(req_page), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .init_done(init_done), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .dram_addr(dram_addr), .dram_din(dram_din), .dram_dout(dram_dout));
  dramc_dram_model dramc_dram_model_inst (.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .dram_addr(dram_addr), .dram_din(dram_din), .dram_dout(dram_dout),
    .ref_cnt(ref_cnt), .late_cnt(late_cnt));

  // 25 MHz clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // one request; waits for the take, then for the answer of a read or rmw
  task automatic access(input logic [1:0] op, input logic [15:0] a, input logic wd,
                        output logic d);
    int k;
    req_op    = op;
    req_addr  = a;
    req_wdata = wd;
    req_valid = 1'b1;
    k = 0;
    // ready seen high off the edge, so the next rising edge takes the request
    while (req_ready !== 1'b1 && k < 200) begin
      @(negedge mclk);
      k++;
    end
    @(negedge mclk);
    req_valid = 1'b0;
    d = 1'bx;
    if (op != OP_WRITE) begin
      k = 1;
      while (rsp_valid !== 1'b1 && k < 20) begin
        @(negedge mclk);
        k++;
      end
      check("rsp_latency", 16'(k >= 4 && k <= 5), 16'h0001);
      d = rsp_rdata;
    end
    @(negedge mclk);
  endtask : access

  // bounded wait for the next read answer, sampled off the edge
  task automatic wait_rsp(output logic d);
    int k;
    k = 0;
    do begin
      @(negedge mclk);
      k++;
    end while (rsp_valid !== 1'b1 && k < 200);
    d = rsp_rdata;
  endtask : wait_rsp

  // two reads in one row, held open through the page flag
  task automatic page_pair(input logic [15:0] a, input logic [15:0] b,
                           output logic d1, output logic d2);
    int r0;
    req_op    = OP_READ;
    req_addr  = a;
    req_page  = 1'b1;
    req_valid = 1'b1;
    wait_rsp(d1);
    r0 = ras_rise;
    req_addr = b;
    wait_rsp(d2);
    req_valid = 1'b0;
    req_page  = 1'b0;
    check("page_row_held", 16'(ras_rise - r0), 16'h0000);
    @(negedge mclk);
  endtask : page_pair

  // hang ceiling and shortest row-high run, sampled off the edge
  always @(negedge mclk) begin
    cycles++;
    if (ras_n === 1'b1) hi_run++;
    else begin
      if (hi_run > 0 && hi_run < min_hi) min_hi = hi_run;
      hi_run = 0;
    end
    if (cycles >= 20000) begin
      errors++;
      give_verdict();
    end
  end
  always @(posedge ras_n) ras_rise++;

  initial begin
    {rst, req_valid, req_wdata, req_page} = 4'h8;
    req_op   = OP_READ;
    req_addr = 16'h0000;
    min_hi   = 1000;
    repeat (20) @(negedge mclk);
    check("ready_in_reset", {15'h0, req_ready}, 16'h0000);
    rst = 1'b0;
    n = 0;
    while (init_done !== 1'b1 && n < 2000) begin
      @(negedge mclk);
      n++;
    end
    check("warmup_cycles", 16'(ref_cnt >= 8), 16'h0001);
    // early writes at corner addresses, halves swapped in two of them
    r = late_cnt;
    foreach (tbl[i]) access(OP_WRITE, tbl[i], ~tbl[i][0], rd);
    check("no_late_strobe", late_cnt - r, 16'h0000);
    foreach (tbl[i]) begin
      check("cell", {15'h0, dramc_dram_model_inst.mem[tbl[i]]}, {15'h0, ~tbl[i][0]});
      access(OP_READ, tbl[i], 1'b0, rd);
      check("read_back", {15'h0, rd}, {15'h0, ~tbl[i][0]});
    end
    // read-modify-write returns the old bit and stores the new one
    r = late_cnt;
    access(OP_RMW, 16'h3c3c, 1'b1, rd);
    check("rmw_old", {15'h0, rd}, 16'h0000);
    access(OP_RMW, 16'h3c3c, 1'b0, rd);
    check("rmw_stored", {15'h0, rd}, 16'h0001);
    check("rmw_strobes", late_cnt - r, 16'h0002);
    // page pair started just after a refresh so none falls between
    access(OP_WRITE, 16'h5501, 1'b0, rd);
    access(OP_WRITE, 16'h55fe, 1'b1, rd);
    r = ref_cnt;
    wait (ref_cnt != r);
    @(negedge mclk);
    page_pair(16'h5501, 16'h55fe, rd, rd2);
    check("page_first", {15'h0, rd}, 16'h0000);
    check("page_second", {15'h0, rd2}, 16'h0001);
    // idle: periodic refresh keeps its spacing
    r = ref_cnt;
    repeat (800) @(negedge mclk);
    check("refresh_spacing", 16'((ref_cnt - r) >= 2 && (ref_cnt - r) <= 3), 16'h0001);
    check("row_precharge", 16'(min_hi >= RP_CYC), 16'h0001);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
